// >>> core/sdp_ram.sv
// two-port synchronous ram with counters and selectable output latency
`timescale 1ns/1ps
`default_nettype none
module sdp_ram
  import sdp_pkg::*;
(
  // clock and reset
  input wire logic I_REF_CLK,
  input wire logic I_RESET_N,
  // port a
  input wire sdp_ctl_t I_A_CTL,
  input wire logic I_A_OE_N,
  input wire logic I_A_LAT_SEL,
  input wire logic [SDP_ADDR_W-1:0] I_A_ADDR,
  input wire logic [SDP_DATA_W-1:0] I_A_DIN,
  output logic [SDP_DATA_W-1:0] O_A_DOUT,
  output logic O_A_DOUT_OE_N,
  // port b
  input wire sdp_ctl_t I_B_CTL,
  input wire logic I_B_OE_N,
  input wire logic I_B_LAT_SEL,
  input wire logic [SDP_ADDR_W-1:0] I_B_ADDR,
  input wire logic [SDP_DATA_W-1:0] I_B_DIN,
  output logic [SDP_DATA_W-1:0] O_B_DOUT,
  output logic O_B_DOUT_OE_N
);
  logic [SDP_DATA_W-1:0] mem [SDP_DEPTH];
  sdp_ctl_t ctl [2];
  logic [SDP_ADDR_W-1:0] ext_addr [2];
  logic [SDP_DATA_W-1:0] din [2];
  logic lat [2];
  logic oe_n [2];
  logic [SDP_ADDR_W-1:0] cnt_r [2];
  logic [SDP_ADDR_W-1:0] addr_nxt [2];
  logic sel_now [2];
  logic sel1_r [2];
  logic sel2_r [2];
  logic rd_r [2];
  logic rd2_r [2];
  logic rd_now [2];
  logic [SDP_DATA_W-1:0] q1_r [2];
  logic drv_r [2];
  logic dout_oe_n_r [2];

  function automatic logic selected(input sdp_ctl_t c);
    selected = !c.cs_low_n && c.cs_high;
  endfunction : selected

  assign ctl[0] = I_A_CTL;
  assign ctl[1] = I_B_CTL;
  assign ext_addr[0] = I_A_ADDR;
  assign ext_addr[1] = I_B_ADDR;
  assign din[0] = I_A_DIN;
  assign din[1] = I_B_DIN;
  assign lat[0] = I_A_LAT_SEL;
  assign lat[1] = I_B_LAT_SEL;
  assign oe_n[0] = I_A_OE_N;
  assign oe_n[1] = I_B_OE_N;

  // both ports come from one generate body so they stay identical
  for (genvar p = 0; p < 2; p++) begin : g_port
    // clear beats load beats advance; advance ignores the selects
    always_comb begin
      if (!ctl[p].cnt_clr_n) begin
        addr_nxt[p] = SDP_ADDR_RST;
      end else if (!ctl[p].addr_load_n) begin
        addr_nxt[p] = ext_addr[p];
      end else if (!ctl[p].cnt_adv_n) begin
        addr_nxt[p] = cnt_r[p] + 16'h0001;
      end else begin
        addr_nxt[p] = cnt_r[p];
      end
    end
    assign sel_now[p] = selected(ctl[p]);
    assign rd_now[p] = sel_now[p] && ctl[p].wr_n;

    always_ff @(posedge I_REF_CLK or negedge I_RESET_N) begin
      if (!I_RESET_N) begin
        cnt_r[p] <= SDP_ADDR_RST;
      end else begin
        cnt_r[p] <= addr_nxt[p];
      end
    end

    // select pipeline: one stage flow-through, two stages pipelined
    always_ff @(posedge I_REF_CLK or negedge I_RESET_N) begin
      if (!I_RESET_N) begin
        sel1_r[p] <= 1'b0;
        sel2_r[p] <= 1'b0;
        rd_r[p] <= 1'b0;
        rd2_r[p] <= 1'b0;
      end else begin
        sel1_r[p] <= sel_now[p];
        sel2_r[p] <= sel1_r[p];
        rd_r[p] <= rd_now[p];
        rd2_r[p] <= rd_r[p];
      end
    end

    // read path; the extra register gives pipelined mode its cycle
    always_ff @(posedge I_REF_CLK or negedge I_RESET_N) begin
      if (!I_RESET_N) begin
        q1_r[p] <= SDP_DATA_RST;
      end else if (rd_now[p]) begin
        q1_r[p] <= mem[addr_nxt[p]];
      end
    end

    always_comb begin
      if (lat[p]) begin
        drv_r[p] = sel2_r[p] && rd2_r[p];
      end else begin
        drv_r[p] = sel1_r[p] && rd_r[p];
      end
      // output enable gates drivers without a clock edge
      dout_oe_n_r[p] = !(drv_r[p] && !oe_n[p]);
    end
  end

  // write: a same-address read on the other port sees the old byte
  // for one edge, which is why a close reader must wait
  always_ff @(posedge I_REF_CLK) begin
    for (int p = 0; p < 2; p++) begin
      if (sel_now[p] && !ctl[p].wr_n) begin
        mem[addr_nxt[p]] <= din[p];
      end
    end
  end

  // data flops; the enable stays combinational so that it is asynchronous
  // flow-through data stands until the next read, not every edge
  always_ff @(posedge I_REF_CLK or negedge I_RESET_N) begin
    if (!I_RESET_N) begin
      O_A_DOUT <= SDP_DATA_RST;
      O_B_DOUT <= SDP_DATA_RST;
    end else begin
      if (lat[0]) begin
        O_A_DOUT <= q1_r[0];
      end else if (rd_now[0]) begin
        O_A_DOUT <= mem[addr_nxt[0]];
      end
      if (lat[1]) begin
        O_B_DOUT <= q1_r[1];
      end else if (rd_now[1]) begin
        O_B_DOUT <= mem[addr_nxt[1]];
      end
    end
  end
  assign O_A_DOUT_OE_N = dout_oe_n_r[0];
  assign O_B_DOUT_OE_N = dout_oe_n_r[1];

  property p_sel_float;
    @(posedge I_REF_CLK) disable iff (!I_RESET_N)
      (!selected(I_A_CTL) && !I_A_LAT_SEL) |=> O_A_DOUT_OE_N;
  endproperty
  a_sel_float: assert property (p_sel_float) else $error("a not floated");
  property p_pipe_sel;
    @(posedge I_REF_CLK) disable iff (!I_RESET_N)
      (!selected(I_B_CTL) && I_B_LAT_SEL) |=> ##1 O_B_DOUT_OE_N;
  endproperty
  a_pipe_sel: assert property (p_pipe_sel) else $error("pipe deselect");
  property p_clr;
    @(posedge I_REF_CLK) disable iff (!I_RESET_N)
      !I_A_CTL.cnt_clr_n |=> cnt_r[0] == SDP_ADDR_RST;
  endproperty
  a_clr: assert property (p_clr) else $error("clear failed");
  property p_load;
    @(posedge I_REF_CLK) disable iff (!I_RESET_N)
      (I_A_CTL.cnt_clr_n && !I_A_CTL.addr_load_n) |=>
        cnt_r[0] == $past(I_A_ADDR);
  endproperty
  a_load: assert property (p_load) else $error("load failed");
  property p_adv;
    @(posedge I_REF_CLK) disable iff (!I_RESET_N)
      (I_B_CTL.cnt_clr_n && I_B_CTL.addr_load_n && !I_B_CTL.cnt_adv_n)
        |=> cnt_r[1] == $past(cnt_r[1]) + 16'h0001;
  endproperty
  a_adv: assert property (p_adv) else $error("advance failed");
  property p_oe;
    @(posedge I_REF_CLK) disable iff (!I_RESET_N)
      I_B_OE_N |-> O_B_DOUT_OE_N;
  endproperty
  a_oe: assert property (p_oe) else $error("oe ignored");
  // mirrors on the other port for the oe, advance and load checks; clear and hold are checked on port a only, float on a flow-through and b pipelined
  property p_oe_a;
    @(posedge I_REF_CLK) disable iff (!I_RESET_N)
      I_A_OE_N |-> O_A_DOUT_OE_N;
  endproperty
  a_oe_a: assert property (p_oe_a) else $error("a oe ignored");
  property p_adv_a;
    @(posedge I_REF_CLK) disable iff (!I_RESET_N)
      (I_A_CTL.cnt_clr_n && I_A_CTL.addr_load_n && !I_A_CTL.cnt_adv_n)
        |=> cnt_r[0] == $past(cnt_r[0]) + 16'h0001;
  endproperty
  a_adv_a: assert property (p_adv_a) else $error("a advance failed");
  property p_load_b;
    @(posedge I_REF_CLK) disable iff (!I_RESET_N)
      (I_B_CTL.cnt_clr_n && !I_B_CTL.addr_load_n) |=>
        cnt_r[1] == $past(I_B_ADDR);
  endproperty
  a_load_b: assert property (p_load_b) else $error("b load failed");
  // a write or idle edge must leave flow-through data where it was
  property p_ft_hold;
    @(posedge I_REF_CLK) disable iff (!I_RESET_N)
      (!(selected(I_A_CTL) && I_A_CTL.wr_n) && !I_A_LAT_SEL) |=>
        $stable(O_A_DOUT);
  endproperty
  a_ft_hold: assert property (p_ft_hold) else $error("a data moved");
  property p_ft_rd;
    @(posedge I_REF_CLK) disable iff (!I_RESET_N)
      (selected(I_A_CTL) && I_A_CTL.wr_n && !I_A_LAT_SEL) ##1
        (!I_A_OE_N && !I_A_LAT_SEL) |-> !O_A_DOUT_OE_N;
  endproperty
  a_ft_rd: assert property (p_ft_rd) else $error("ft read off");
  property p_pl_rd;
    @(posedge I_REF_CLK) disable iff (!I_RESET_N)
      (selected(I_B_CTL) && I_B_CTL.wr_n && I_B_LAT_SEL) ##1
        selected(I_B_CTL) ##1 (!I_B_OE_N && I_B_LAT_SEL) |-> !O_B_DOUT_OE_N;
  endproperty
  a_pl_rd: assert property (p_pl_rd) else $error("pipe read off");
  c_wr: cover property (@(posedge I_REF_CLK) selected(I_A_CTL) && !I_A_CTL.wr_n);
  c_rd: cover property (@(posedge I_REF_CLK) !O_B_DOUT_OE_N);
  c_clr: cover property (@(posedge I_REF_CLK) !I_A_CTL.cnt_clr_n);
  c_adv: cover property (@(posedge I_REF_CLK) !I_B_CTL.cnt_adv_n);
endmodule : sdp_ram
`default_nettype wire

// >>> common/sdp_pkg.sv
// package for the synchronous dual-port ram port logic
package sdp_pkg;
  localparam int SDP_ADDR_W = 16;
  localparam int SDP_DATA_W = 8;
  localparam int SDP_DEPTH = 65536;
  localparam logic [15:0] SDP_ADDR_RST = 16'h0000;
  localparam logic [7:0] SDP_DATA_RST = 8'h00;
  localparam int SDP_CLK_NS = 10;
  localparam int SDP_CWDD_NS = 24;
  localparam int SDP_CWDD_CYC = (SDP_CWDD_NS + SDP_CLK_NS - 1) / SDP_CLK_NS;
  typedef struct packed {
    logic cs_low_n;
    logic cs_high;
    logic wr_n;
    logic addr_load_n;
    logic cnt_adv_n;
    logic cnt_clr_n;
  } sdp_ctl_t;
endpackage : sdp_pkg

// >>> bench/sdp_host.sv
// host model driving one ram port
`timescale 1ns/1ps
`default_nettype none
module sdp_host
  import sdp_pkg::*;
#(
  parameter logic LAT = 1'b0
)(
  // toward the ram port
  output var sdp_ctl_t o_ctl,
  output logic [SDP_ADDR_W-1:0] o_addr,
  output logic [SDP_DATA_W-1:0] o_din,
  output logic o_lat
);
  assign o_lat = LAT;
  initial begin
    o_ctl = 6'h2f;
    o_addr = 16'h0000;
    o_din = 8'h00;
  end
  // called just after a rising edge, one request per edge
  task drive(input sdp_ctl_t c, input logic [15:0] a, input logic [7:0] d);
    o_ctl = c;
    o_addr = a;
    // reads leave the data lines toggling, not stale
    o_din = c.wr_n ? ~o_din : d;
  endtask : drive
endmodule : sdp_host
`default_nettype wire

// >>> bench/sdp_ram_bench.sv
// self-checking bench for the dual-port ram
`timescale 1ns/1ps
`default_nettype none
module sdp_ram_bench
  import sdp_pkg::*;
;
  typedef struct packed {
    logic [7:0] c;
    logic [15:0] a;
    logic [7:0] d;
    logic [3:0] k;
    logic [7:0] q;
  } sdp_row_t;
  logic clk, rst_n, a_oe_n, b_oe_n, a_lat, b_lat, a_oen, b_oen;
  sdp_ctl_t a_ctl, b_ctl;
  logic [15:0] a_addr, b_addr;
  logic [7:0] a_din, b_din, a_dout, b_dout;
  int err_total = 0;
  int n_tests = 0;
  // k: 0 no check, 1 data and enable, 2 enable off only
  sdp_row_t rows [14] = '{44'h13_0010_a5_0_00, 44'h13_0011_3c_0_00,
    44'h13_0012_5a_0_00, 44'h13_0000_77_0_00, 44'h03_0010_ff_0_00,
    44'h1b_0011_00_1_3c, 44'h1b_0010_00_1_a5, 44'h2d_0000_00_2_00,
    44'h1f_0000_00_1_3c, 44'h1d_0000_00_1_5a, 44'h0b_0010_00_2_00,
    44'h1b_0010_00_1_a5, 44'h3b_0010_00_2_00, 44'h1e_0000_00_1_77};
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  sdp_host #(.LAT(1'b0)) sdp_host_a_i (.o_ctl(a_ctl), .o_addr(a_addr),
    .o_din(a_din), .o_lat(a_lat));
  sdp_host #(.LAT(1'b1)) sdp_host_b_i (.o_ctl(b_ctl), .o_addr(b_addr),
    .o_din(b_din), .o_lat(b_lat));
  sdp_ram sdp_ram_i (.I_REF_CLK(clk), .I_RESET_N(rst_n),
    .I_A_CTL(a_ctl), .I_A_OE_N(a_oe_n), .I_A_LAT_SEL(a_lat),
    .I_A_ADDR(a_addr), .I_A_DIN(a_din), .O_A_DOUT(a_dout),
    .O_A_DOUT_OE_N(a_oen), .I_B_CTL(b_ctl), .I_B_OE_N(b_oe_n),
    .I_B_LAT_SEL(b_lat), .I_B_ADDR(b_addr), .I_B_DIN(b_din),
    .O_B_DOUT(b_dout), .O_B_DOUT_OE_N(b_oen));
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    n_tests++;
    if (seen !== exp) begin
      err_total++;
      $display("unexpected at %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : chk
  task automatic tick;
    @(posedge clk);
    #1;
  endtask : tick
  task automatic stop_test;
    $display("checks %0d mismatches %0d", n_tests, err_total);
    if (err_total == 0 && n_tests > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask : stop_test
  initial begin
    #(400 * SDP_CLK_NS);
    err_total++;
    stop_test();
  end
  initial begin
    rst_n = 1'b0;
    a_oe_n = 1'b0;
    b_oe_n = 1'b0;
    repeat (5) @(posedge clk);
    #1 rst_n = 1'b1;
    foreach (rows[i]) begin
      sdp_host_a_i.drive(rows[i].c[5:0], rows[i].a, rows[i].d);
      tick();
      if (rows[i].k != 4'h0) chk({7'h00, a_oen}, {7'h00, rows[i].k[1]});
      if (rows[i].k == 4'h1) chk(a_dout, rows[i].q);
    end
    $display("row table done");
    // pipelined port b: data and select both one edge later
    sdp_host_b_i.drive(6'h1b, 16'h0010, 8'h00);
    tick();
    chk({7'h00, b_oen}, 8'h01);
    sdp_host_b_i.drive(6'h1d, 16'h0000, 8'h00);
    tick();
    chk(b_dout, 8'ha5);
    sdp_host_b_i.drive(6'h2f, 16'h0000, 8'h00);
    tick();
    chk({7'h00, b_oen}, 8'h00);
    chk(b_dout, 8'h3c);
    b_oe_n = 1'b1;
    #1 chk({7'h00, b_oen}, 8'h01);
    tick();
    b_oe_n = 1'b0;
    chk({7'h00, b_oen}, 8'h01);
    $display("pipelined port done");
    sdp_host_b_i.drive(6'h13, 16'h0020, 8'h4e);
    tick();
    sdp_host_b_i.drive(6'h2f, 16'h0000, 8'h00);
    // reader holds off a cycle past the write edge
    tick();
    sdp_host_a_i.drive(6'h1b, 16'h0020, 8'h00);
    tick();
    chk(a_dout, 8'h4e);
    a_oe_n = 1'b1;
    #1 chk({7'h00, a_oen}, 8'h01);
    tick();
    a_oe_n = 1'b0;
    #1 chk({7'h00, a_oen}, 8'h00);
    $display("cross port and enable done");
    rst_n = 1'b0;
    #1 chk({7'h00, a_oen}, 8'h01);
    chk(a_dout, 8'h00);
    tick();
    rst_n = 1'b1;
    tick();
    chk(a_dout, 8'h4e);
    chk({7'h00, a_oen}, 8'h00);
    $display("reset done");
    stop_test();
  end
endmodule : sdp_ram_bench
`default_nettype wire
